// [pkg/ees_map.svh]
// constants for the serial eeprom slave: codes, sizes and timing
`ifndef EES_MAP_SVH
`define EES_MAP_SVH
// ************************************************
// address byte type codes
// ************************************************
`define EES_TYPE_MAIN 4'ha
`define EES_TYPE_ID 4'hb
// ************************************************
// organisation
// ************************************************
`define EES_ADDR_W 9
`define EES_PAGE_W 4
`define EES_BYTE_LAST 4'h7
`define EES_ACK_DONE 4'h9
`define EES_TX_DONE 4'h8
// pin synchroniser reset: bus clock and data bits sit at their pulled-up idle level
`define EES_PIN_IDLE 6'h03
// ************************************************
// timing
// ************************************************
`define EES_PROG_TIME_US 4000
`define EES_CORE_CLK_MHZ 50
`define EES_PROG_CYCLES (`EES_PROG_TIME_US * `EES_CORE_CLK_MHZ)
`define EES_SCL_MAX_KHZ 1000
`endif

// [pkg/ees_pkg.sv]
// types shared by the serial eeprom slave
package ees_pkg;
   typedef enum logic [2:0] {S_IDLE, S_RX, S_RXEND, S_ACK, S_TX, S_MACK, S_IGNORE} ees_state_t;
   typedef enum logic [1:0] {PH_DEV, PH_ADDR, PH_DATA, PH_READ} ees_phase_t;
endpackage : ees_pkg

// [hw/ees_link_sampler.sv]
// bus clock side bit sampler with a toggle crossing into the core clock
`timescale 1ns/1ps
module ees_link_sampler (
   input wire logic i_scl_clk,
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_sda_i,
   output logic o_bit_ev,
   output logic o_bit
);
   logic link_bit_q;
   logic link_tog_q;
   logic tog_meta_q;
   logic tog_s1_q;
   logic tog_s2_q;

   // ************************************************
   // bus clock domain
   // ************************************************
   // data is sampled on the rising bus clock edge, where the master keeps it stable
   always_ff @(posedge i_scl_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         link_bit_q <= 1'b0;
         link_tog_q <= 1'b0;
      end else begin
         link_bit_q <= i_sda_i;
         link_tog_q <= ~link_tog_q;
      end
   end

   // ************************************************
   // core clock domain
   // ************************************************
   // toggle synchroniser; the sampled bit stays put for a whole bus period, so it is
   // safe to take once the toggle has crossed
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tog_meta_q <= 1'b0;
         tog_s1_q <= 1'b0;
         tog_s2_q <= 1'b0;
         o_bit_ev <= 1'b0;
         o_bit <= 1'b0;
      end else begin
         tog_meta_q <= link_tog_q;
         tog_s1_q <= tog_meta_q;
         tog_s2_q <= tog_s1_q;
         o_bit_ev <= tog_s1_q ^ tog_s2_q;
         if (tog_s1_q ^ tog_s2_q) begin
            o_bit <= link_bit_q;
         end
      end
   end
endmodule : ees_link_sampler

// [hw/ees_slave_top.sv]
// two-wire serial eeprom slave: bus decode, page buffer, self-timed programming
`timescale 1ns/1ps
`include "ees_map.svh"
module ees_slave_top #(
   parameter int P_PAGE_W = `EES_PAGE_W,
   parameter int P_PROG_CYCLES = `EES_PROG_CYCLES,
   parameter bit P_ID_PAGE = 1'b1
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_scl_clk,
   input wire logic i_sda_i,
   output logic o_sda_o,
   output logic o_sda_oe,
   input wire logic i_supply_ok,
   input wire logic i_wp,
   input wire logic i_addr_strap_low,
   input wire logic i_addr_strap_high,
   input wire logic i_wp_unlock,
   input wire logic i_id_lock,
   output logic o_busy,
   output logic o_standby,
   output logic o_id_locked
);
   import ees_pkg::*;

   localparam int AW = `EES_ADDR_W;
   localparam int PB = 1 << P_PAGE_W;
   localparam int CW = $clog2(P_PROG_CYCLES + 1);

   // ************************************************
   // elaboration checks
   // ************************************************
   if (P_PAGE_W < 1 || P_PAGE_W > 8 || P_PROG_CYCLES < 1) begin : g_bad_param
      $error("ees_slave_top: page width or programming count out of range");
   end

   // ************************************************
   // pin synchronisers
   // ************************************************
   logic [5:0] pin_meta_q;
   logic [5:0] pin_sync_q;
   logic scl_d_q;
   logic sda_d_q;
   logic supply_s, wp_s, strap_hi_s, strap_lo_s, scl_s, sda_s;

   // two flops on the supply, protect, strap, clock and data pins; straps left open are pulled to zero at the pad
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_meta_q <= `EES_PIN_IDLE; // idle-high lines avoid a false clock fall after reset
         pin_sync_q <= `EES_PIN_IDLE;
         scl_d_q <= 1'b1;
         sda_d_q <= 1'b1;
      end else begin
         pin_meta_q <= {i_supply_ok, i_wp, i_addr_strap_high, i_addr_strap_low, i_scl_clk, i_sda_i};
         pin_sync_q <= pin_meta_q;
         scl_d_q <= scl_s;
         sda_d_q <= sda_s;
      end
   end
   assign {supply_s, wp_s, strap_hi_s, strap_lo_s, scl_s, sda_s} = pin_sync_q;

   // conditions seen at 50 MHz; 1 MHz bus leaves over 13 samples per high phase
   logic start_c, stop_c, scl_fall;
   assign start_c = scl_s && scl_d_q && sda_d_q && !sda_s;
   assign stop_c = scl_s && scl_d_q && !sda_d_q && sda_s;
   assign scl_fall = scl_d_q && !scl_s;

   logic bit_ev, bit_v;
   ees_link_sampler u_sampler (
      .i_scl_clk(i_scl_clk),
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_sda_i(i_sda_i),
      .o_bit_ev(bit_ev),
      .o_bit(bit_v)
   );

   // ************************************************
   // address byte decode
   // ************************************************
   function automatic logic dev_type_ok(input logic [3:0] t, input logic id_en);
      dev_type_ok = (t == `EES_TYPE_MAIN) || (id_en && t == `EES_TYPE_ID);
   endfunction : dev_type_ok

   ees_state_t st_q;
   ees_phase_t phase_q;
   logic [3:0] cnt_q;
   logic [6:0] sh_q;
   logic [7:0] tx_q;
   logic [AW-1:0] ptr_q;
   logic id_sel_q;
   logic ack_q;
   logic busy_q;
   logic lock_q;
   logic [CW-1:0] prog_cnt_q;
   logic [PB-1:0] mask_q;
   logic [7:0] buf_q [PB];
   logic [7:0] mem_q [1 << AW]; // main array
   logic [7:0] id_mem_q [PB];

   logic [7:0] rx_byte;
   logic byte_done, dev_hit, prot, wr_pending, prog_start, prog_done;
   logic [7:0] rd_data;
   assign rx_byte = {sh_q, bit_v};
   assign byte_done = (st_q == S_RX) && bit_ev && (cnt_q == `EES_BYTE_LAST);
   // type, both straps, then block bit and read flag
   assign dev_hit = dev_type_ok(rx_byte[7:4], P_ID_PAGE) && rx_byte[3:2] == {strap_hi_s, strap_lo_s};
   // unlock overrides the pin; a locked id page refuses writes
   assign prot = id_sel_q ? lock_q : (wp_s && !i_wp_unlock);
   assign wr_pending = (phase_q == PH_DATA) && (|mask_q);
   assign prog_start = stop_c && supply_s && !busy_q && wr_pending && !prot;
   assign prog_done = busy_q && (prog_cnt_q == CW'(P_PROG_CYCLES - 1));
   assign rd_data = id_sel_q ? id_mem_q[ptr_q[P_PAGE_W-1:0]] : mem_q[ptr_q];

   // ************************************************
   // bus state machine
   // ************************************************
   // supply low overrides everything, so nothing is acked while it rises or falls
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q <= S_IDLE;
         phase_q <= PH_DEV;
         cnt_q <= 4'h0;
         sh_q <= 7'h00;
         tx_q <= 8'hff;
         ptr_q <= '0;
         id_sel_q <= 1'b0;
         ack_q <= 1'b0;
         o_sda_oe <= 1'b0;
      end else if (!supply_s) begin
         st_q <= S_IDLE;
         o_sda_oe <= 1'b0;
      end else if (start_c) begin
         st_q <= S_RX;
         phase_q <= PH_DEV;
         cnt_q <= 4'h0;
         o_sda_oe <= 1'b0;
      end else if (stop_c) begin
         st_q <= S_IDLE;
         o_sda_oe <= 1'b0;
      end else begin
         unique case (st_q)
            S_IDLE, S_IGNORE: begin
            end
            S_RX: begin
               if (bit_ev) begin
                  sh_q <= rx_byte[6:0];
                  cnt_q <= cnt_q + 4'h1;
               end
               if (byte_done) begin
                  st_q <= S_RXEND;
                  ack_q <= 1'b1;
                  // bytes are taken as device, then address, then data
                  unique case (phase_q)
                     PH_DEV: begin
                        if (dev_hit && !busy_q) begin
                           id_sel_q <= (rx_byte[7:4] == `EES_TYPE_ID);
                           if (rx_byte[7:4] == `EES_TYPE_MAIN) begin
                              ptr_q[AW-1] <= rx_byte[1];
                           end
                           phase_q <= rx_byte[0] ? PH_READ : PH_ADDR;
                        end else begin
                           ack_q <= 1'b0;
                        end
                     end
                     PH_ADDR: begin
                        ptr_q[AW-2:0] <= rx_byte;
                        phase_q <= PH_DATA;
                     end
                     PH_DATA: begin
                        // only the page offset moves, wrapping inside the page
                        ptr_q[P_PAGE_W-1:0] <= ptr_q[P_PAGE_W-1:0] + 1'b1;
                     end
                     PH_READ: begin
                        ack_q <= 1'b0;
                     end
                  endcase
               end
            end
            S_RXEND: begin
               if (scl_fall) begin
                  o_sda_oe <= ack_q;
                  st_q <= ack_q ? S_ACK : S_IGNORE;
               end
            end
            S_ACK: begin
               if (bit_ev) begin
                  cnt_q <= `EES_ACK_DONE;
               end
               if (scl_fall && cnt_q == `EES_ACK_DONE) begin
                  cnt_q <= 4'h0;
                  if (phase_q == PH_READ) begin
                     st_q <= S_TX;
                     o_sda_oe <= !rd_data[7];
                     tx_q <= {rd_data[6:0], 1'b1};
                     if (id_sel_q) begin
                        ptr_q[P_PAGE_W-1:0] <= ptr_q[P_PAGE_W-1:0] + 1'b1;
                     end else begin
                        ptr_q <= ptr_q + 1'b1;
                     end
                  end else begin
                     st_q <= S_RX;
                     o_sda_oe <= 1'b0;
                  end
               end
            end
            S_TX: begin
               if (bit_ev) begin
                  cnt_q <= cnt_q + 4'h1;
               end
               if (scl_fall) begin
                  if (cnt_q == `EES_TX_DONE) begin
                     o_sda_oe <= 1'b0;
                     st_q <= S_MACK;
                  end else begin
                     o_sda_oe <= !tx_q[7]; // a one is sent by releasing the line
                     tx_q <= {tx_q[6:0], 1'b1};
                  end
               end
            end
            S_MACK: begin
               // master ack fetches the next byte on the coming fall; nack ends the read
               if (bit_ev) begin
                  cnt_q <= `EES_ACK_DONE;
                  st_q <= bit_v ? S_IGNORE : S_ACK;
               end
            end
         endcase
      end
   end

   // open drain: the data output flop only ever holds low
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_sda_o <= 1'b0;
      end else begin
         o_sda_o <= 1'b0;
      end
   end

   // ************************************************
   // page buffer and byte mask
   // ************************************************
   // only bytes received get their mask bit, so the rest of the page is untouched
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mask_q <= '0;
      end else if (prog_done || !supply_s) begin
         mask_q <= '0;
      end else if (byte_done && phase_q == PH_ADDR) begin
         mask_q <= '0;
      end else if (byte_done && phase_q == PH_DATA) begin
         mask_q[ptr_q[P_PAGE_W-1:0]] <= 1'b1;
      end else if ((stop_c || start_c) && !busy_q && !prog_start) begin
         mask_q <= '0; // protected or aborted writes are dropped here
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (byte_done && phase_q == PH_DATA) begin
         buf_q[ptr_q[P_PAGE_W-1:0]] <= rx_byte;
      end
   end

   // ************************************************
   // self-timed programming
   // ************************************************
   // the cycle runs on the core clock alone; a supply drop abandons it
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         busy_q <= 1'b0;
         prog_cnt_q <= '0;
      end else if (!supply_s) begin
         busy_q <= 1'b0;
         prog_cnt_q <= '0;
      end else if (prog_start) begin
         busy_q <= 1'b1;
         prog_cnt_q <= '0;
      end else if (prog_done) begin
         busy_q <= 1'b0;
      end else if (busy_q) begin
         prog_cnt_q <= prog_cnt_q + 1'b1;
      end
   end

   // the masked bytes of the page are committed in one go at the end of the cycle
   always_ff @(posedge i_core_clk) begin
      if (prog_done) begin
         for (int i = 0; i < PB; i++) begin
            if (mask_q[i] && id_sel_q) begin
               id_mem_q[i] <= buf_q[i];
            end else if (mask_q[i]) begin
               mem_q[{ptr_q[AW-1:P_PAGE_W], i[P_PAGE_W-1:0]}] <= buf_q[i];
            end
         end
      end
   end

   // lock is sticky; the reset here stands in for the cell's erased state
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lock_q <= 1'b0;
      end else if (i_id_lock) begin
         lock_q <= 1'b1;
      end
   end

   // ************************************************
   // status outputs
   // ************************************************
   // standby only once the bus is idle and no programming runs
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_busy <= 1'b0;
         o_standby <= 1'b1;
         o_id_locked <= 1'b0;
      end else begin
         o_busy <= busy_q;
         o_standby <= (st_q == S_IDLE) && !busy_q;
         o_id_locked <= lock_q;
      end
   end

   // ************************************************
   // assertions
   // ************************************************
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_dev_byte;
      byte_done && phase_q == PH_DEV;
   endsequence
   sequence s_stop_write;
      stop_c && supply_s && !busy_q && wr_pending;
   endsequence

   a_por_quiet: assert property (!supply_s |=> !o_sda_oe)
      else $error("data line driven while supply low");
   a_por_standby: assert property ($rose(supply_s) |-> st_q == S_IDLE)
      else $error("not idle when supply came up");
   a_pdown_idle: assert property ($fell(supply_s) |=> st_q == S_IDLE ##1 !o_busy)
      else $error("no standby after supply fell");
   a_stop_idle: assert property (stop_c && supply_s |=> st_q == S_IDLE)
      else $error("stop did not return to idle");
   a_busy_nak: assert property (s_dev_byte ##0 busy_q |=> !ack_q)
      else $error("address acked while programming");
   a_strap_nak: assert property (s_dev_byte ##0 (rx_byte[3:2] != {strap_hi_s, strap_lo_s}) |=> !ack_q)
      else $error("address acked with wrong straps");
   a_wp_block: assert property (s_stop_write ##0 (!id_sel_q && wp_s && !i_wp_unlock) |=> !busy_q)
      else $error("protected main array programmed");
   a_wr_start: assert property (s_stop_write ##0 !prot |=> busy_q ##1 o_busy)
      else $error("allowed write did not start programming");
   a_id_locked: assert property (s_stop_write ##0 (id_sel_q && lock_q) |=> !busy_q)
      else $error("locked id page programmed");
   a_prog_len: assert property (busy_q |-> prog_cnt_q < CW'(P_PROG_CYCLES))
      else $error("programming overran its time");
   a_page_wrap: assert property (byte_done && phase_q == PH_DATA |=>
         ptr_q[AW-1:P_PAGE_W] == $past(ptr_q[AW-1:P_PAGE_W]))
      else $error("page write left its page");
   a_data_ack: assert property (st_q == S_RXEND && phase_q == PH_DATA && scl_fall && supply_s |=> o_sda_oe)
      else $error("data byte not acked");
endmodule : ees_slave_top

// [sim/ees_bus_master.sv]
// two-wire bus master model: drives the serial clock and pulls the data line
`timescale 1ns/1ps
module ees_bus_master (
   output logic o_scl,
   output logic o_sda_oe,
   input wire logic i_sda
);
   // quarter bit in 15 ns ticks: 4 x 17 x 15 ns keeps the bus just under 1 MHz
   localparam int PH = 17;
   // clock idles high and stands still between frames; data line released
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end
   task automatic tk();
      #(PH * 15);
   endtask : tk
   // one clock pulse; data changes only while the clock is low, sampled mid-high
   task automatic bit_io(input logic b, output logic s);
      tk();
      o_sda_oe <= ~b;
      tk();
      o_scl <= 1'b1;
      tk();
      s = i_sda;
      tk();
      o_scl <= 1'b0;
   endtask : bit_io
   // start or repeated start: data falls while the clock is high
   task automatic start();
      tk();
      o_sda_oe <= 1'b0;
      tk();
      o_scl <= 1'b1;
      tk();
      o_sda_oe <= 1'b1;
      tk();
      o_scl <= 1'b0;
   endtask : start
   // stop: data rises while the clock is high, then the clock stays high
   task automatic stop();
      tk();
      o_sda_oe <= 1'b1;
      tk();
      o_scl <= 1'b1;
      tk();
      o_sda_oe <= 1'b0;
      tk();
   endtask : stop
   // byte out msb first, then the device's acknowledge bit (line released)
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask : wr_byte
   // byte in, then our acknowledge; a nack on the last byte ends a read
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(last, s);
   endtask : rd_byte
endmodule : ees_bus_master

// [sim/test_serial_eeprom_slave_4kbit.sv]
// self-checking bench for the serial eeprom slave
`timescale 1ns/1ps
`include "ees_map.svh"
module test_serial_eeprom_slave_4kbit;
   // programming shortened, yet long enough to poll the device during it
   localparam int P_PROG = 1200;
   logic i_core_clk, i_rst_n, i_supply_ok, i_wp, i_wp_unlock, i_id_lock, st_h, st_l, k;
   logic o_sda_o, o_sda_oe, o_busy, o_standby, o_id_locked, scl, m_oe, sda_w;
   logic [7:0] mem [512];
   logic [7:0] idm [16];
   logic [15:0] run = 16'h0;
   logic [15:0] busy_len = 16'h0;
   int n_errors = 0;
   int comparisons = 0;
   // open-drain wire with pull-up: low whenever either side pulls
   assign sda_w = ~(m_oe | o_sda_oe);
   ees_slave_top #(.P_PROG_CYCLES(P_PROG)) dut (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_scl_clk(scl),
      .i_sda_i(sda_w), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
      .i_supply_ok(i_supply_ok), .i_wp(i_wp), .i_addr_strap_low(st_l),
      .i_addr_strap_high(st_h), .i_wp_unlock(i_wp_unlock), .i_id_lock(i_id_lock),
      .o_busy(o_busy), .o_standby(o_standby), .o_id_locked(o_id_locked)
   );
   ees_bus_master m (.o_scl(scl), .o_sda_oe(m_oe), .i_sda(sda_w));
   // ********************
   // checking helpers
   // ********************
   initial begin
      i_core_clk = 1'b0;
      forever #10 i_core_clk = ~i_core_clk;
   end
   task automatic chk_flag(input string nm, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_flag
   task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_val
   task automatic wrap_up();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up
   // length of the last busy run, to time the self-timed programming
   always @(posedge i_core_clk) begin
      if (o_busy === 1'b1) begin
         run <= run + 16'h1;
      end else if (run != 16'h0) begin
         busy_len <= run;
         run <= 16'h0;
      end
   end
   // the device may only ever pull the data line low
   always @(posedge i_core_clk) begin
      if (o_sda_oe === 1'b1) begin
         chk_flag("sda_o", 1'b0, o_sda_o);
      end
   end
   // watchdog: traffic should take about 1.1 ms, so 1.8 ms means a hang
   initial begin
      #1_800_000;
      n_errors++;
      wrap_up();
   end
   function automatic logic [7:0] devb(input logic id, input logic blk, input logic rw);
      return {id ? `EES_TYPE_ID : `EES_TYPE_MAIN, st_h, st_l, blk, rw};
   endfunction : devb
   task automatic cyc(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask : cyc
   // ********************
   // bus transactions
   // ********************
   task automatic probe(input logic [7:0] b, input logic e);
      logic a;
      m.start();
      m.wr_byte(b, a);
      m.stop();
      chk_flag("ack_probe", e, a);
   endtask : probe
   task automatic hdr(input logic id, input logic [8:0] a);
      logic a1;
      m.start();
      m.wr_byte(devb(id, a[8], 1'b0), a1);
      chk_flag("ack_dev", 1'b1, a1);
      m.wr_byte(a[7:0], a1);
      chk_flag("ack_addr", 1'b1, a1);
   endtask : hdr
   // shadow follows the in-page wrap of the write pointer
   task automatic wr(input logic id, input logic [8:0] a, input int n, input logic [7:0] b, input logic upd);
      logic a1;
      logic [8:0] p;
      hdr(id, a);
      for (int i = 0; i < n; i++) begin
         p = {a[8:4], a[3:0] + 4'(i)};
         m.wr_byte(b + 8'(i), a1);
         chk_flag("ack_data", 1'b1, a1);
         if (upd && id) idm[p[3:0]] = b + 8'(i);
         else if (upd) mem[p] = b + 8'(i);
      end
      m.stop();
   endtask : wr
   // random read: address write, repeated start, sequential bytes
   task automatic rd(input logic id, input logic [8:0] a, input int n);
      logic a1;
      logic [7:0] d;
      hdr(id, a);
      m.start();
      m.wr_byte(devb(id, a[8], 1'b1), a1);
      chk_flag("ack_rd", 1'b1, a1);
      for (int i = 0; i < n; i++) begin
         m.rd_byte(i == n - 1, d);
         chk_val("rd", {8'h0, id ? idm[a[3:0] + 4'(i)] : mem[a + 9'(i)]}, {8'h0, d});
      end
      m.stop();
   endtask : rd
   task automatic wait_prog();
      int t;
      t = 0;
      @(negedge i_core_clk);
      chk_flag("busy", 1'b1, o_busy);
      chk_flag("standby_busy", 1'b0, o_standby);
      while (o_busy !== 1'b0 && t < 3000) begin
         @(negedge i_core_clk);
         t++;
      end
      repeat (3) @(negedge i_core_clk);
      chk_val("busy_len", 16'(P_PROG), busy_len);
      chk_flag("standby", 1'b1, o_standby);
   endtask : wait_prog
   task automatic quiet();
      repeat (30) @(negedge i_core_clk);
      chk_flag("no_prog", 1'b0, o_busy);
   endtask : quiet
   // ********************
   // test sequence
   // ********************
   initial begin
      i_rst_n = 1'b0;
      i_supply_ok = 1'b0;
      i_wp = 1'b0;
      i_wp_unlock = 1'b0;
      i_id_lock = 1'b0;
      st_h = 1'b0;
      st_l = 1'b0;
      cyc(16);
      @(negedge i_core_clk);
      chk_flag("rst_standby", 1'b1, o_standby);
      chk_flag("rst_lock", 1'b0, o_id_locked);
      @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      cyc(6);
      probe(devb(1'b0, 1'b0, 1'b0), 1'b0);
      @(posedge i_core_clk);
      i_supply_ok <= 1'b1;
      cyc(6);
      @(negedge i_core_clk);
      chk_flag("sup_standby", 1'b1, o_standby);
      // straps open (zero) first, then the high strap set; only a match acks
      for (int s = 0; s < 2; s++) begin
         for (int j = 0; j < 4; j++) begin
            probe({`EES_TYPE_MAIN, 2'(j), 2'b00}, 2'(j) == (s ? 2'b10 : 2'b00));
         end
         @(posedge i_core_clk);
         st_h <= 1'b1;
         cyc(4);
      end
      probe({4'h9, 2'b10, 2'b00}, 1'b0);
      wr(1'b0, 9'h120, 16, 8'h30, 1'b1);
      probe(devb(1'b0, 1'b1, 1'b0), 1'b0);
      wait_prog();
      wr(1'b0, 9'h12e, 4, 8'hc0, 1'b1);
      wait_prog();
      wr(1'b0, 9'h020, 1, 8'h77, 1'b1);
      wait_prog();
      rd(1'b0, 9'h120, 16);
      rd(1'b0, 9'h020, 1);
      // protected write is acked but dropped; unlock lets it through
      @(posedge i_core_clk);
      i_wp <= 1'b1;
      cyc(4);
      wr(1'b0, 9'h124, 2, 8'h90, 1'b0);
      quiet();
      rd(1'b0, 9'h124, 2);
      @(posedge i_core_clk);
      i_wp_unlock <= 1'b1;
      wr(1'b0, 9'h124, 1, 8'he1, 1'b1);
      wait_prog();
      rd(1'b0, 9'h123, 3);
      @(posedge i_core_clk);
      i_wp <= 1'b0;
      i_wp_unlock <= 1'b0;
      // identification page, then locked against further writes
      wr(1'b1, 9'h003, 2, 8'h5a, 1'b1);
      wait_prog();
      @(posedge i_core_clk);
      i_id_lock <= 1'b1;
      @(posedge i_core_clk);
      i_id_lock <= 1'b0;
      repeat (3) @(negedge i_core_clk);
      chk_flag("id_locked", 1'b1, o_id_locked);
      wr(1'b1, 9'h003, 1, 8'ha5, 1'b0);
      quiet();
      rd(1'b1, 9'h003, 2);
      // supply drop in mid-write: back to standby, nothing programmed
      hdr(1'b0, 9'h121);
      m.wr_byte(8'h11, k);
      @(posedge i_core_clk);
      i_supply_ok <= 1'b0;
      repeat (6) @(negedge i_core_clk);
      chk_flag("drop_standby", 1'b1, o_standby);
      @(posedge i_core_clk);
      i_supply_ok <= 1'b1;
      cyc(6);
      m.stop();
      quiet();
      rd(1'b0, 9'h121, 1);
      wrap_up();
   end
endmodule : test_serial_eeprom_slave_4kbit
